/* wcsm_top.sv */
// top of the waveform capture serial master: control on clk, shifter on link_clk
// assumes link_clk runs free near LINK_CLK_KHZ and rst is asynchronous, active high
//
// Notes on behaviour
// - port off after reset, on by bit 6
// - runs only in two-wire host mode
// - sixteen words in fixed slot order
// - 24-bit samples sign-extended to 32 bits
// - missing variant slots send zero words
// - master driving select, data and clock
// - data and select high after reset
// - bit 0 picks 8 or 4 MHz
// - new data bit on each falling edge except those starting gap cycles
// - bit 1 picks word or byte packages, msb-first
// - bit 2 inserts seven-cycle gaps
// - without gaps package size ignored, continuous
// - selection 00 sends all sixteen words
// - selection 01 sends seven wave words
// - selection 10 sends nine power words
// - selection 11 behaves as 00
// - bit 5 inverts select levels
// - setup bits 7 and 6 ignored
// - long transfers go every second update
// - durations follow clock, size, gap settings
module wcsm_top #(
	parameter bit HAS_NEUTRAL  = 1'b1,
	parameter bit HAS_REACTIVE = 1'b1
) (
	input  wire logic                             clk,
	input  wire logic                             rst,
	input  wire logic                             link_clk,
	input  wire logic                             setup_wr,
	input  wire logic [wcsm_pkg::SETUP_W-1:0]     setup_wdata,
	output logic      [wcsm_pkg::SETUP_W-1:0]     setup_rdata,
	input  wire logic [7:0]                       global_config,
	input  wire logic                             i2c_mode,
	input  wire logic                             sample_update,
	input  wire logic [wcsm_pkg::SAMPLE_W-1:0]    sample_word [wcsm_pkg::NUM_WORDS],
	output logic                                  transfer_busy,
	output logic                                  capture_serial_clock,
	output logic                                  capture_data_out,
	output logic                                  capture_select_out
);

	wcsm_link_if lnk ();

	wcsm_capture_ctrl #(
		.HAS_NEUTRAL  (HAS_NEUTRAL),
		.HAS_REACTIVE (HAS_REACTIVE)
	) u_ctrl (
		.clk           (clk),
		.rst           (rst),
		.setup_wr      (setup_wr),
		.setup_wdata   (setup_wdata),
		.setup_rdata   (setup_rdata),
		.global_config (global_config),
		.i2c_mode      (i2c_mode),
		.sample_update (sample_update),
		.sample_word   (sample_word),
		.busy          (transfer_busy),
		.lnk           (lnk.ctrl)
	);

	// link-side reset: asserted at once, released on link_clk
	logic lrst_s1_q;
	logic lrst_q;

	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			lrst_s1_q <= 1'b1;
			lrst_q    <= 1'b1;
		end else begin
			lrst_s1_q <= 1'b0;
			lrst_q    <= lrst_s1_q;
		end
	end

	// crossings into the link domain
	logic st_s1_q;
	logic st_s2_q;
	logic st_s3_q;
	logic st_acc_q;
	logic pol_s1_q;
	logic pol_s2_q;
	logic pol_s3_q;
	logic pol_q;
	wire  logic start_evt;

	assign start_evt = (st_s2_q == st_s3_q) && (st_s2_q != st_acc_q);

	always_ff @(posedge link_clk or posedge lrst_q) begin
		if (lrst_q) begin
			st_s1_q  <= 1'b0;
			st_s2_q  <= 1'b0;
			st_s3_q  <= 1'b0;
			st_acc_q <= 1'b0;
		end else begin
			st_s1_q  <= lnk.start_tgl;
			st_s2_q  <= st_s1_q;
			st_s3_q  <= st_s2_q;
			st_acc_q <= start_evt ? st_s2_q : st_acc_q;
		end
	end

	always_ff @(posedge link_clk or posedge lrst_q) begin
		if (lrst_q) begin
			pol_s1_q <= 1'b0;
			pol_s2_q <= 1'b0;
			pol_s3_q <= 1'b0;
			pol_q    <= 1'b0;
		end else begin
			pol_s1_q <= lnk.pol;
			pol_s2_q <= pol_s1_q;
			pol_s3_q <= pol_s2_q;
			pol_q    <= (pol_s2_q == pol_s3_q) ? pol_s2_q : pol_q;
		end
	end

	// shifter state
	wcsm_pkg::wcsm_state_e          state_q;
	wcsm_pkg::wcsm_state_e          state_d;
	logic [wcsm_pkg::DIV_W-1:0]     div_q;
	logic [wcsm_pkg::DIV_W-1:0]     div_d;
	logic                           phase_q;
	logic                           phase_d;
	logic [wcsm_pkg::BIT_W-1:0]     bit_q;
	logic [wcsm_pkg::BIT_W-1:0]     bit_d;
	logic [wcsm_pkg::IDX_W-1:0]     widx_q;
	logic [wcsm_pkg::IDX_W-1:0]     widx_d;
	logic [2:0]                     gapc_q;
	logic [2:0]                     gapc_d;
	logic                           sclk_q;
	logic                           sclk_d;
	logic                           data_q;
	logic                           data_d;
	logic                           sel_q;
	logic                           sel_d;
	logic                           done_q;
	logic                           done_d;

	wire  logic [wcsm_pkg::DIV_W-1:0] half;
	wire  logic                       tick;
	wire  logic                       last_bit;
	wire  logic                       last_word;
	wire  logic                       end_pkg;
	wire  logic [wcsm_pkg::BIT_W-1:0] nb;
	wire  logic [wcsm_pkg::IDX_W-1:0] nw;
	wire  logic                       next_data;
	wire  logic                       first_data;

	assign half       = lnk.slow ? wcsm_pkg::HALF_SLOW : wcsm_pkg::HALF_FAST;
	assign tick       = (div_q == half - 4'h1);
	assign last_bit   = (bit_q == wcsm_pkg::WORD_LAST_BIT);
	assign last_word  = (widx_q == lnk.last_idx);
	assign end_pkg    = lnk.size8 ? (bit_q[2:0] == wcsm_pkg::BYTE_LAST_BIT) : last_bit;
	assign nb         = bit_q + 5'h01;
	assign nw         = last_bit ? widx_q + 4'h1 : widx_q;
	assign next_data  = lnk.word[nw][wcsm_pkg::WORD_LAST_BIT - nb];
	assign first_data = lnk.word[lnk.first_idx][wcsm_pkg::WORD_LAST_BIT];

	always_comb begin
		state_d = state_q;
		phase_d = phase_q;
		bit_d   = bit_q;
		widx_d  = widx_q;
		gapc_d  = gapc_q;
		sclk_d  = sclk_q;
		data_d  = data_q;
		done_d  = done_q;
		case (state_q)
			wcsm_pkg::WCSM_IDLE: begin
				if (start_evt) begin
					state_d = wcsm_pkg::WCSM_SHIFT;
					phase_d = 1'b0;
					bit_d   = '0;
					widx_d  = lnk.first_idx;
					sclk_d  = 1'b0;
					data_d  = first_data;
				end
			end
			wcsm_pkg::WCSM_SHIFT: begin
				if (tick) begin
					if (!phase_q) begin
						sclk_d  = 1'b1;
						phase_d = 1'b1;
					end else if (last_bit && last_word) begin
						state_d = wcsm_pkg::WCSM_IDLE;
						done_d  = ~done_q;
					end else if (lnk.gap && end_pkg) begin
						state_d = wcsm_pkg::WCSM_GAP;
						gapc_d  = '0;
						sclk_d  = 1'b0;
						phase_d = 1'b0;
					end else begin
						sclk_d  = 1'b0;
						phase_d = 1'b0;
						bit_d   = nb;
						widx_d  = nw;
						data_d  = next_data;
					end
				end
			end
			wcsm_pkg::WCSM_GAP: begin
				if (tick) begin
					if (!phase_q) begin
						sclk_d  = 1'b1;
						phase_d = 1'b1;
					end else if (gapc_q == wcsm_pkg::GAP_LAST) begin
						state_d = wcsm_pkg::WCSM_SHIFT;
						sclk_d  = 1'b0;
						phase_d = 1'b0;
						bit_d   = nb;
						widx_d  = nw;
						data_d  = next_data;
					end else begin
						gapc_d  = gapc_q + 3'h1;
						sclk_d  = 1'b0;
						phase_d = 1'b0;
					end
				end
			end
			default: begin
				state_d = wcsm_pkg::WCSM_IDLE;
			end
		endcase
	end

	assign div_d = ((state_q == wcsm_pkg::WCSM_IDLE) || tick) ? '0 : div_q + 4'h1;
	assign sel_d = ~((state_d == wcsm_pkg::WCSM_SHIFT) ^ pol_q);

	always_ff @(posedge link_clk or posedge lrst_q) begin
		if (lrst_q) begin
			state_q <= wcsm_pkg::WCSM_IDLE;
			div_q   <= '0;
			phase_q <= 1'b0;
			bit_q   <= '0;
			widx_q  <= '0;
			gapc_q  <= '0;
			done_q  <= 1'b0;
		end else begin
			state_q <= state_d;
			div_q   <= div_d;
			phase_q <= phase_d;
			bit_q   <= bit_d;
			widx_q  <= widx_d;
			gapc_q  <= gapc_d;
			done_q  <= done_d;
		end
	end

	// output stage: data and select high from reset, clock idles high
	always_ff @(posedge link_clk or posedge lrst_q) begin
		if (lrst_q) begin
			sclk_q <= 1'b1;
			data_q <= 1'b1;
			sel_q  <= 1'b1;
		end else begin
			sclk_q <= sclk_d;
			data_q <= data_d;
			sel_q  <= sel_d;
		end
	end

	assign lnk.done_tgl         = done_q;
	assign capture_serial_clock = sclk_q;
	assign capture_data_out     = data_q;
	assign capture_select_out   = sel_q;

endmodule

/* wcsm_pkg.sv */
// constants, field positions and types of the waveform capture serial master
// assumes nothing beyond a systemverilog compiler
package wcsm_pkg;

	localparam int unsigned NUM_WORDS  = 16;
	localparam int unsigned WORD_W     = 32;
	localparam int unsigned SAMPLE_W   = 24;
	localparam int unsigned IDX_W      = 4;
	localparam int unsigned BIT_W      = 5;
	localparam int unsigned SETUP_W    = 8;
	localparam int unsigned DIV_W      = 4;

	// setup register fields
	localparam int unsigned SETUP_SLOW_BIT = 0;
	localparam int unsigned SETUP_SIZE_BIT = 1;
	localparam int unsigned SETUP_GAP_BIT  = 2;
	localparam int unsigned SETUP_SEL_LO   = 3;
	localparam int unsigned SETUP_SEL_HI   = 4;
	localparam int unsigned SETUP_POL_BIT  = 5;
	localparam logic [SETUP_W-1:0] SETUP_RESET = 8'h00;

	// global setup register: port enable position
	localparam int unsigned CONFIG_ENABLE_BIT = 6;

	// word slots in transmit order
	localparam int unsigned IDX_FIRST          = 0;
	localparam int unsigned IDX_NEUTRAL        = 6;
	localparam int unsigned IDX_POWER_FIRST    = 7;
	localparam int unsigned IDX_REACTIVE_FIRST = 13;
	localparam int unsigned IDX_LAST           = 15;

	// package and gap shape
	localparam logic [BIT_W-1:0] WORD_LAST_BIT = 5'h1f;
	localparam logic [2:0]       BYTE_LAST_BIT = 3'h7;
	localparam int unsigned      GAP_CYCLES    = 7;
	localparam logic [2:0]       GAP_LAST      = 3'(GAP_CYCLES - 1);

	// serial clock derived from the link clock
	localparam int unsigned LINK_CLK_KHZ  = 66667;
	localparam int unsigned SCLK_FAST_KHZ = 8000;
	localparam int unsigned SCLK_SLOW_KHZ = 4000;
	localparam int unsigned HALF_FAST_RAW = LINK_CLK_KHZ / (2 * SCLK_FAST_KHZ);
	localparam int unsigned HALF_SLOW_RAW = LINK_CLK_KHZ / (2 * SCLK_SLOW_KHZ);
	localparam logic [DIV_W-1:0] HALF_FAST = DIV_W'((HALF_FAST_RAW < 1) ? 1 : HALF_FAST_RAW);
	localparam logic [DIV_W-1:0] HALF_SLOW = DIV_W'((HALF_SLOW_RAW < 1) ? 1 : HALF_SLOW_RAW);

	typedef enum logic [1:0] {
		WCSM_SEL_ALL    = 2'b00,
		WCSM_SEL_WAVES  = 2'b01,
		WCSM_SEL_POWERS = 2'b10,
		WCSM_SEL_RSVD   = 2'b11
	} wcsm_sel_e;

	typedef enum logic [1:0] {
		WCSM_IDLE  = 2'b00,
		WCSM_SHIFT = 2'b01,
		WCSM_GAP   = 2'b11
	} wcsm_state_e;

endpackage

/* wcsm_link_if.sv */
// signals passed between the system-clock control and the link-clock shifter
// assumes words and settings stay still from a start toggle until its done toggle
interface wcsm_link_if;
	logic                         start_tgl;
	logic                         done_tgl;
	logic [wcsm_pkg::WORD_W-1:0]  word [wcsm_pkg::NUM_WORDS];
	logic                         slow;
	logic                         size8;
	logic                         gap;
	logic                         pol;
	logic [wcsm_pkg::IDX_W-1:0]   first_idx;
	logic [wcsm_pkg::IDX_W-1:0]   last_idx;

	modport ctrl (
		output start_tgl,
		output word,
		output slow,
		output size8,
		output gap,
		output pol,
		output first_idx,
		output last_idx,
		input  done_tgl
	);

	modport link (
		input  start_tgl,
		input  word,
		input  slow,
		input  size8,
		input  gap,
		input  pol,
		input  first_idx,
		input  last_idx,
		output done_tgl
	);
endinterface

/* wcsm_capture_ctrl.sv */
// system-clock side: setup register, enable gating, snapshot and transfer pacing
// assumes sample_update is a one-cycle strobe on clk at the waveform update rate
module wcsm_capture_ctrl #(
	parameter bit HAS_NEUTRAL  = 1'b1,
	parameter bit HAS_REACTIVE = 1'b1
) (
	input  wire logic                             clk,
	input  wire logic                             rst,
	input  wire logic                             setup_wr,
	input  wire logic [wcsm_pkg::SETUP_W-1:0]     setup_wdata,
	output logic      [wcsm_pkg::SETUP_W-1:0]     setup_rdata,
	input  wire logic [7:0]                       global_config,
	input  wire logic                             i2c_mode,
	input  wire logic                             sample_update,
	input  wire logic [wcsm_pkg::SAMPLE_W-1:0]    sample_word [wcsm_pkg::NUM_WORDS],
	output logic                                  busy,
	wcsm_link_if.ctrl                             lnk
);

	logic [wcsm_pkg::SETUP_W-1:0] setup_q;
	logic                         busy_q;
	logic                         start_tgl_q;
	logic                         done_s1_q;
	logic                         done_s2_q;
	logic                         done_s3_q;
	logic                         done_acc_q;
	logic                         slow_q;
	logic                         size8_q;
	logic                         gap_q;
	logic [wcsm_pkg::IDX_W-1:0]   first_q;
	logic [wcsm_pkg::IDX_W-1:0]   last_q;
	wcsm_pkg::wcsm_sel_e          sel;
	wire  logic                   port_on;
	wire  logic                   start;
	wire  logic                   done_evt;
	wire  logic [wcsm_pkg::IDX_W-1:0] first_d;
	wire  logic [wcsm_pkg::IDX_W-1:0] last_d;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			setup_q <= wcsm_pkg::SETUP_RESET;
		end else if (setup_wr) begin
			setup_q <= setup_wdata;
		end
	end

	assign setup_rdata = setup_q;
	assign sel = wcsm_pkg::wcsm_sel_e'(setup_q[wcsm_pkg::SETUP_SEL_HI:wcsm_pkg::SETUP_SEL_LO]);
	assign port_on = global_config[wcsm_pkg::CONFIG_ENABLE_BIT] & i2c_mode;
	assign first_d = (sel == wcsm_pkg::WCSM_SEL_POWERS) ? 4'(wcsm_pkg::IDX_POWER_FIRST)
	                                                    : 4'(wcsm_pkg::IDX_FIRST);
	assign last_d  = (sel == wcsm_pkg::WCSM_SEL_WAVES) ? 4'(wcsm_pkg::IDX_NEUTRAL)
	                                                   : 4'(wcsm_pkg::IDX_LAST);
	assign done_evt = (done_s2_q == done_s3_q) && (done_s2_q != done_acc_q);
	assign start = sample_update & port_on & ~busy_q;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			done_s1_q  <= 1'b0;
			done_s2_q  <= 1'b0;
			done_s3_q  <= 1'b0;
			done_acc_q <= 1'b0;
		end else begin
			done_s1_q  <= lnk.done_tgl;
			done_s2_q  <= done_s1_q;
			done_s3_q  <= done_s2_q;
			done_acc_q <= done_evt ? done_s2_q : done_acc_q;
		end
	end

	// a busy port skips the update, so long transfers go every second update
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_q <= 1'b0;
		end else if (start) begin
			busy_q <= 1'b1;
		end else if (done_evt) begin
			busy_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			start_tgl_q <= 1'b0;
			slow_q      <= 1'b0;
			size8_q     <= 1'b0;
			gap_q       <= 1'b0;
			first_q     <= '0;
			last_q      <= '0;
		end else if (start) begin
			start_tgl_q <= ~start_tgl_q;
			slow_q      <= setup_q[wcsm_pkg::SETUP_SLOW_BIT];
			size8_q     <= setup_q[wcsm_pkg::SETUP_SIZE_BIT];
			gap_q       <= setup_q[wcsm_pkg::SETUP_GAP_BIT];
			first_q     <= first_d;
			last_q      <= last_d;
		end
	end

	// snapshot of every slot at the start of a transfer
	for (genvar i = 0; i < wcsm_pkg::NUM_WORDS; i++) begin : g_snap
		localparam bit ABSENT = ((i == wcsm_pkg::IDX_NEUTRAL) && !HAS_NEUTRAL) ||
		                        ((i >= wcsm_pkg::IDX_REACTIVE_FIRST) && !HAS_REACTIVE);
		logic [wcsm_pkg::WORD_W-1:0] word_q;
		wire  logic [wcsm_pkg::WORD_W-1:0] ext;
		assign ext = ABSENT ? '0 : {{8{sample_word[i][wcsm_pkg::SAMPLE_W-1]}}, sample_word[i]};
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				word_q <= '0;
			end else if (start) begin
				word_q <= ext;
			end
		end
		assign lnk.word[i] = word_q;
	end

	assign lnk.start_tgl = start_tgl_q;
	assign lnk.slow      = slow_q;
	assign lnk.size8     = size8_q;
	assign lnk.gap       = gap_q;
	assign lnk.first_idx = first_q;
	assign lnk.last_idx  = last_q;
	assign lnk.pol       = setup_q[wcsm_pkg::SETUP_POL_BIT];
	assign busy          = busy_q;

endmodule

/* wcsm_rx_model.sv */
// receiving spi slave of the capture port, no return line to the master
// assumes select is active at level pol and clr is pulsed between transfers
module wcsm_rx_model (
	input  wire logic        sclk,
	input  wire logic        sdo,
	input  wire logic        sel,
	input  wire logic        pol,
	input  wire logic        clr,
	output logic      [31:0] words [16],
	output int               nbits,
	output int               ngaps
);
	timeunit 1ns;
	timeprecision 100ps;
	always @(posedge sclk or posedge clr) begin
		if (clr) begin
			nbits <= 0;
			ngaps <= 0;
		end else if (sel == pol && nbits < 512) begin
			words[nbits / 32] <= {words[nbits / 32][30:0], sdo};
			nbits <= nbits + 1;
		end else begin
			ngaps <= ngaps + 1;
		end
	end
endmodule

/* wcsm_top_props.sv */
// concurrent checks on the ports of wcsm_top
// assumes setup only changes while no transfer runs
module wcsm_top_props #(
	parameter bit HAS_NEUTRAL  = 1'b1,
	parameter bit HAS_REACTIVE = 1'b1
) (
	input wire logic                         clk,
	input wire logic                         rst,
	input wire logic                         link_clk,
	input wire logic                         setup_wr,
	input wire logic [wcsm_pkg::SETUP_W-1:0] setup_wdata,
	input wire logic [wcsm_pkg::SETUP_W-1:0] setup_rdata,
	input wire logic [7:0]                   global_config,
	input wire logic                         i2c_mode,
	input wire logic                         sample_update,
	input wire logic                         transfer_busy,
	input wire logic                         capture_serial_clock,
	input wire logic                         capture_data_out,
	input wire logic                         capture_select_out
);
	sequence s_lo_fast;
		(!capture_serial_clock)[*4] ##1 capture_serial_clock;
	endsequence
	sequence s_lo_slow;
		(!capture_serial_clock)[*8] ##1 capture_serial_clock;
	endsequence
	a_fast_half: assert property (@(posedge link_clk) disable iff (rst)
		!setup_rdata[0] && $fell(capture_serial_clock) |-> s_lo_fast) else $error("fast half wrong");
	a_slow_half: assert property (@(posedge link_clk) disable iff (rst)
		setup_rdata[0] && $fell(capture_serial_clock) |-> s_lo_slow) else $error("slow half wrong");
	a_data_on_fall: assert property (@(posedge link_clk) disable iff (rst)
		$changed(capture_data_out) |-> $fell(capture_serial_clock)) else $error("data moved off fall");
	a_sel_in_bits: assert property (@(posedge link_clk) disable iff (rst)
		$changed(capture_data_out) |-> capture_select_out == setup_rdata[5])
		else $error("select inactive in bit");
	a_idle_sclk_high: assert property (@(posedge link_clk) disable iff (rst)
		!transfer_busy |-> capture_serial_clock) else $error("clock moved while idle");
	a_start_needs_enable: assert property (@(posedge clk) disable iff (rst)
		$rose(transfer_busy) |-> $past(global_config[6]) && $past(sample_update))
		else $error("start without enable");
	a_start_two_wire: assert property (@(posedge clk) disable iff (rst)
		$rose(transfer_busy) |-> $past(i2c_mode)) else $error("start outside two-wire mode");
	a_start_taken: assert property (@(posedge clk) disable iff (rst)
		sample_update && global_config[6] && i2c_mode && !transfer_busy |=> transfer_busy)
		else $error("update not taken");
	a_busy_holds: assert property (@(posedge clk) disable iff (rst)
		$rose(transfer_busy) |-> transfer_busy[*8]) else $error("transfer too short");
	a_setup_store: assert property (@(posedge clk) disable iff (rst)
		setup_wr |=> setup_rdata == $past(setup_wdata)) else $error("setup not stored");
	a_reset_lines: assert property (@(posedge clk) disable iff (rst)
		$fell(rst) |-> capture_data_out && capture_select_out && capture_serial_clock)
		else $error("lines not high after reset");
endmodule

bind wcsm_top wcsm_top_props #(.HAS_NEUTRAL(HAS_NEUTRAL), .HAS_REACTIVE(HAS_REACTIVE)) i_props (
	.clk, .rst, .link_clk, .setup_wr, .setup_wdata, .setup_rdata, .global_config, .i2c_mode,
	.sample_update, .transfer_busy, .capture_serial_clock, .capture_data_out, .capture_select_out);

/* waveform_capture_serial_master_bench.sv */
// self-checking bench of the waveform capture serial master
// assumes wcsm_pkg, the design files and the receiver model compile first
module waveform_capture_serial_master_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk = 0;
	logic        rst = 1;
	logic        link_clk = 0;
	logic        setup_wr = 0;
	logic [7:0]  setup_wdata = 8'h00;
	logic [7:0]  setup_rdata;
	logic [7:0]  global_config = 8'h00;
	logic        i2c_mode = 1;
	logic        sample_update = 0;
	logic [23:0] smp [16];
	logic        busy, sclk, sdo, sel;
	logic        pol = 0;
	logic        rx_clr = 0;
	logic [31:0] rx_w [16];
	logic [31:0] exp_w [16];
	logic [31:0] seed = 32'h0a21859b;
	int          err_total = 0;
	int          checks_done = 0;
	int          cyc = 0;
	int          rx_bits, rx_gaps;
	logic        sclk_v, sdo_v, sel_v;
	logic [31:0] rx_v [16];
	int          rxv_bits, rxv_gaps;
	logic [7:0]  tbl [9] = '{8'h00, 8'h01, 8'h06, 8'h0c, 8'h11, 8'h18, 8'h20, 8'hc2, 8'h07};

	wcsm_top i_dut (.clk, .rst, .link_clk, .setup_wr, .setup_wdata, .setup_rdata, .global_config,
		.i2c_mode, .sample_update, .sample_word(smp), .transfer_busy(busy),
		.capture_serial_clock(sclk), .capture_data_out(sdo), .capture_select_out(sel));
	wcsm_rx_model i_rx (.sclk, .sdo, .sel, .pol, .clr(rx_clr), .words(rx_w), .nbits(rx_bits),
		.ngaps(rx_gaps));
	// variant without neutral and reactive slots, same stimulus
	wcsm_top #(.HAS_NEUTRAL(1'b0), .HAS_REACTIVE(1'b0)) i_dut_lean (.clk, .rst, .link_clk,
		.setup_wr, .setup_wdata, .setup_rdata(), .global_config, .i2c_mode, .sample_update,
		.sample_word(smp), .transfer_busy(), .capture_serial_clock(sclk_v),
		.capture_data_out(sdo_v), .capture_select_out(sel_v));
	wcsm_rx_model i_rx_lean (.sclk(sclk_v), .sdo(sdo_v), .sel(sel_v), .pol, .clr(rx_clr),
		.words(rx_v), .nbits(rxv_bits), .ngaps(rxv_gaps));

	always #20 clk = ~clk;
	initial begin
		#3.3;
		forever #7.5 link_clk = ~link_clk;
	end

	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	function automatic logic [31:0] xw(input int k);
		return {{8{smp[k][23]}}, smp[k]};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want) begin
			err_total++;
			$display("mismatch at %0t: saw %h, expected %h", $time, seen, want);
		end
	endtask
	task automatic test_done;
		$display("checks %0d, mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic tick;
		@(posedge clk);
		#2;
	endtask
	task automatic rnd;
		for (int i = 0; i < 16; i++) begin
			seed = xs(seed);
			smp[i] = seed[23:0];
		end
		smp[0][23] = 1'b1;
		smp[1][23] = 1'b0;
	endtask
	task automatic pulse;
		sample_update = 1;
		tick();
		sample_update = 0;
	endtask
	task automatic no_start(input logic [7:0] gc, input logic im);
		global_config = gc;
		i2c_mode = im;
		rx_clr = 1;
		tick();
		rx_clr = 0;
		pulse();
		repeat (50) tick();
		chk({31'h0, busy}, 32'h0);
		chk(32'(rx_bits), 32'h0);
		i2c_mode = 1;
	endtask
	task automatic run(input logic [7:0] s);
		int n;
		int f;
		int t;
		int g;
		int d;
		n = (s[4:3] == 2'b01) ? 7 : (s[4:3] == 2'b10) ? 9 : 16;
		f = (s[4:3] == 2'b10) ? 7 : 0;
		g = s[2] ? ((s[1] ? 4 : 1) * n - 1) * 7 : 0;
		// ns of shifting: two halves of 15 ns link cycles per serial clock
		d = (n * 32 + g) * 30 * (s[0] ? int'(wcsm_pkg::HALF_SLOW) : int'(wcsm_pkg::HALF_FAST));
		global_config = 8'h00;
		setup_wdata = s;
		setup_wr = 1;
		tick();
		setup_wr = 0;
		global_config = 8'h40;
		pol = s[5];
		rx_clr = 1;
		chk({24'h0, setup_rdata}, {24'h0, s});
		rnd();
		for (int i = 0; i < n; i++) exp_w[i] = xw(f + i);
		tick();
		rx_clr = 0;
		pulse();
		rnd();
		tick();
		pulse();
		chk({31'h0, busy}, 32'h1);
		t = 0;
		while (busy !== 1'b0 && t < 8000) begin
			tick();
			t++;
		end
		chk({31'h0, busy}, 32'h0);
		chk({31'h0, (t * 40 >= d) && (t * 40 <= d + 400)}, 32'h1);
		chk(32'(rx_bits), 32'(n * 32));
		chk(32'(rx_gaps), 32'(g));
		for (int i = 0; i < n; i++) chk(rx_w[i], exp_w[i]);
		chk(32'(rxv_bits), 32'(n * 32));
		chk(32'(rxv_gaps), 32'(g));
		for (int i = 0; i < n; i++)
			chk(rx_v[i], (f + i == 6 || f + i >= 13) ? 32'h0 : exp_w[i]);
		chk({31'h0, sel}, {31'h0, ~s[5]});
		chk({31'h0, sclk}, 32'h1);
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			err_total++;
			test_done();
		end
	end

	initial begin
		rnd();
		repeat (16) @(posedge clk);
		#2 rst = 0;
		repeat (20) tick();
		chk({29'h0, sdo, sel, sclk}, 32'h7);
		chk({24'h0, setup_rdata}, 32'h0);
		no_start(8'h00, 1'b1);
		no_start(8'hbf, 1'b1);
		no_start(8'h40, 1'b0);
		for (int i = 0; i < 9; i++) run(tbl[i]);
		for (int i = 0; i < 2; i++) begin
			seed = xs(seed);
			run(seed[7:0]);
		end
		test_done();
	end
endmodule
